// File: hw/icu_pkg.sv
// Constants and types shared by the interrupt cache utilization engine files
`default_nettype none

package icu_pkg;

  // Cache geometry
  localparam int ENTRIES  = 16;
  localparam int IDX_W    = 4;
  localparam int ID_W     = 16;
  localparam int BANK_CAP = 8;
  localparam int THR_DEN  = 16;

  typedef logic [IDX_W-1:0] idx_t;
  typedef logic [ID_W-1:0]  entry_id_t;
  typedef logic [3:0]       occ_t;
  typedef logic [3:0]       thr_t;

  localparam idx_t LAST_IDX = 4'hf;

  // APB register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;

  // Control register fields
  localparam int MERGE_TRIG_BIT = 31;
  localparam int MERGE_EN_BIT   = 30;
  localparam int MERGE_THR_LSB  = 16;
  localparam int EVICT_TRIG_BIT = 15;
  localparam int EVICT_EN_BIT   = 14;
  localparam int EVICT_THR_LSB  = 0;
  localparam int MERGE_LANE     = 3;
  localparam int MERGE_THR_LANE = 2;
  localparam int EVICT_LANE     = 1;
  localparam int EVICT_THR_LANE = 0;

  // Control register reset values
  localparam logic EN_RST  = 1'b0;
  localparam thr_t THR_RST = 4'hc;

  // Status register fields
  localparam int STAT_MERGE_BUSY_BIT = 0;
  localparam int STAT_EVICT_BUSY_BIT = 1;
  localparam int STAT_OCC0_LSB       = 8;
  localparam int STAT_OCC1_LSB       = 16;

  // Engine states
  typedef enum logic [4:0] {
    M_IDLE = 5'h01,
    M_RDA  = 5'h02,
    M_LDA  = 5'h04,
    M_RDB  = 5'h08,
    M_CMP  = 5'h10
  } merge_state_t;

  typedef enum logic [1:0] {
    E_IDLE = 2'h1,
    E_SCAN = 2'h2
  } evict_state_t;

endpackage : icu_pkg

`default_nettype wire

// File: hw/entry_id_store.sv
// Interrupt ID storage for the cache entries, registered read port
`timescale 1ns/1ns
`default_nettype none

module entry_id_store (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              srst_i,
  // Write port
  input  wire logic              wr_en_i,
  input  wire icu_pkg::idx_t     wr_idx_i,
  input  wire icu_pkg::entry_id_t wr_id_i,
  // Read port
  input  wire logic              rd_en_i,
  input  wire icu_pkg::idx_t     rd_idx_i,
  output icu_pkg::entry_id_t     rd_id_o
);

  icu_pkg::entry_id_t mem [icu_pkg::ENTRIES];

  // Array write, no reset needed for storage
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_id_i;
    end
  end

  // Registered read data
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_id_o <= '0;
    end else if (rd_en_i) begin
      rd_id_o <= mem[rd_idx_i];
    end
  end

endmodule // entry_id_store

`default_nettype wire

// File: hw/fill_level_watch.sv
// Bank fill threshold detector, pulses when either bank reaches the fraction
`timescale 1ns/1ns
`default_nettype none

module fill_level_watch (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  // Bank occupancy and threshold
  input  wire icu_pkg::occ_t occ0_i,
  input  wire icu_pkg::occ_t occ1_i,
  input  wire icu_pkg::thr_t thr_i,
  // Rising edge of the reached condition
  output logic              reach_pulse_o
);

  logic reached;
  logic reached_prev;

  // Occupancy over capacity at least threshold over sixteen
  function automatic logic at_level(input icu_pkg::occ_t occ, input icu_pkg::thr_t thr);
    logic [8:0] lhs;
    logic [8:0] rhs;
    lhs = 9'(occ) * 9'(icu_pkg::THR_DEN);
    rhs = 9'(thr) * 9'(icu_pkg::BANK_CAP);
    return lhs >= rhs;
  endfunction

  assign reached = at_level(occ0_i, thr_i) || at_level(occ1_i, thr_i);

  // Edge memory so one crossing gives one trigger
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      reached_prev <= 1'b0;
    end else begin
      reached_prev <= reached;
    end
  end

  assign reach_pulse_o = reached && !reached_prev;

endmodule // fill_level_watch

`default_nettype wire

// File: hw/intr_cache_util_engine.sv
// Utilization engines and control register for the message interrupt cache
//
// Overview of operation
// R1 - Writing one to the merge trigger bit starts the engine that merges unserialized cached entries of equal ID.
// R2 - The merge trigger is ignored unless the merge enable bit is one.
// R3 - The merge enable bit is read-write, zero holds the engine off and one lets any trigger start it.
// R4 - The merge engine starts by itself when a bank fills to its four-bit threshold over sixteen.
// R5 - Writing one to the evict trigger bit starts the engine that evicts every disabled cached interrupt.
// R6 - The evict trigger does nothing unless the evict enable bit is one at the time of the write.
// R7 - The evict enable bit is read-write, zero holds that engine off and one lets any trigger start it.
// R8 - The evict engine starts by itself when a bank fills to its own four-bit threshold over sixteen.
// R9 - When the cache needs room for a new entry it picks a disabled entry as the victim first.
// R10 - Bits 29 to 20 and 13 to 4 of the control register are reserved and read as zero.
// R11 - Without message interrupt support the triggers and enables change nothing.
// R12 - The register acts only on this chip's caches and nothing of it leaves the chip.
// R13 - The two trigger bits are single-cycle pulses, never stored, and read back as zero.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module intr_cache_util_engine (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              srst_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [icu_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Configuration strap
  input  wire logic              msg_intr_present_i,
  // Entry insertion
  input  wire logic              ins_valid_i,
  input  wire icu_pkg::entry_id_t ins_id_i,
  input  wire logic              ins_enabled_i,
  output logic                   ins_ready_o,
  // Entry updates
  input  wire logic              ser_valid_i,
  input  wire icu_pkg::idx_t     ser_idx_i,
  input  wire logic              en_valid_i,
  input  wire icu_pkg::idx_t     en_idx_i,
  input  wire logic              en_value_i,
  // Eviction report and engine status
  output logic                   evict_valid_o,
  output icu_pkg::idx_t          evict_idx_o,
  output logic                   merge_busy_o,
  output logic                   evict_busy_o
);

  // Control register state
  logic                  merge_en;
  icu_pkg::thr_t         merge_thr;
  logic                  evict_en;
  icu_pkg::thr_t         evict_thr;
  // Cache entry flags
  logic [icu_pkg::ENTRIES-1:0] valid;
  logic [icu_pkg::ENTRIES-1:0] enab;
  logic [icu_pkg::ENTRIES-1:0] ser;
  // Engines
  icu_pkg::merge_state_t m_state;
  icu_pkg::evict_state_t e_state;
  icu_pkg::idx_t         a_idx;
  icu_pkg::idx_t         b_idx;
  icu_pkg::idx_t         e_idx;
  icu_pkg::entry_id_t    a_id;
  icu_pkg::entry_id_t    rd_id;
  // Miscellaneous nets
  logic                  wr_ctrl;
  logic                  setup_rd;
  logic                  merge_man;
  logic                  merge_auto;
  logic                  merge_start;
  logic                  evict_man;
  logic                  evict_auto;
  logic                  evict_start;
  logic                  merge_reach;
  logic                  evict_reach;
  logic                  merge_kill;
  logic                  evict_kill;
  logic                  ins_fire;
  logic                  ins_replace;
  logic [icu_pkg::IDX_W:0] free_pick;
  logic [icu_pkg::IDX_W:0] dis_pick;
  icu_pkg::idx_t         victim;
  icu_pkg::occ_t         occ0;
  icu_pkg::occ_t         occ1;
  logic [31:0]           ctrl_view;
  logic [31:0]           status_view;

  // First zero bit of a vector, lowest index wins
  function automatic logic [icu_pkg::IDX_W:0] pick_first(input logic [icu_pkg::ENTRIES-1:0] vec);
    logic [icu_pkg::IDX_W:0] r;
    r = '0;
    for (int i = icu_pkg::ENTRIES - 1; i >= 0; i--) begin
      if (!vec[i]) begin
        r = {1'b1, icu_pkg::idx_t'(i)};
      end
    end
    return r;
  endfunction

  // Valid entries in one bank
  function automatic icu_pkg::occ_t bank_count(input logic [icu_pkg::ENTRIES-1:0] vec, input logic bank);
    icu_pkg::occ_t n;
    n = '0;
    for (int i = 0; i < icu_pkg::BANK_CAP; i++) begin
      n = n + icu_pkg::occ_t'(vec[(bank ? icu_pkg::BANK_CAP : 0) + i]);
    end
    return n;
  endfunction

  // APB decode; zero wait states
  assign pready_o = 1'b1;
  assign wr_ctrl  = psel_i && penable_i && pwrite_i && (paddr_i == icu_pkg::CTRL_OFFSET);
  assign setup_rd = psel_i && !penable_i;

  // Register read views, triggers and reserved bits give zero
  always_comb begin
    ctrl_view = '0;                                                    // R10 R13
    ctrl_view[icu_pkg::MERGE_EN_BIT] = merge_en;
    ctrl_view[icu_pkg::MERGE_THR_LSB +: 4] = merge_thr;
    ctrl_view[icu_pkg::EVICT_EN_BIT] = evict_en;
    ctrl_view[icu_pkg::EVICT_THR_LSB +: 4] = evict_thr;
    status_view = '0;
    status_view[icu_pkg::STAT_MERGE_BUSY_BIT] = merge_busy_o;
    status_view[icu_pkg::STAT_EVICT_BUSY_BIT] = evict_busy_o;
    status_view[icu_pkg::STAT_OCC0_LSB +: 4] = occ0;
    status_view[icu_pkg::STAT_OCC1_LSB +: 4] = occ1;
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      prdata_o  <= '0;
      pslverr_o <= 1'b0;
    end else if (setup_rd) begin
      pslverr_o <= (paddr_i != icu_pkg::CTRL_OFFSET) && (paddr_i != icu_pkg::STATUS_OFFSET);
      if (pwrite_i) begin
        prdata_o <= '0;
      end else if (paddr_i == icu_pkg::CTRL_OFFSET) begin
        prdata_o <= ctrl_view;
      end else if (paddr_i == icu_pkg::STATUS_OFFSET) begin
        prdata_o <= status_view;
      end else begin
        prdata_o <= '0;
      end
    end
  end

  // Enable and threshold fields, byte lanes honoured
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      merge_en  <= icu_pkg::EN_RST;
      merge_thr <= icu_pkg::THR_RST;
      evict_en  <= icu_pkg::EN_RST;
      evict_thr <= icu_pkg::THR_RST;
    end else if (wr_ctrl) begin
      if (pstrb_i[icu_pkg::MERGE_LANE]) begin
        merge_en <= pwdata_i[icu_pkg::MERGE_EN_BIT];                   // R3
      end
      if (pstrb_i[icu_pkg::MERGE_THR_LANE]) begin
        merge_thr <= pwdata_i[icu_pkg::MERGE_THR_LSB +: 4];
      end
      if (pstrb_i[icu_pkg::EVICT_LANE]) begin
        evict_en <= pwdata_i[icu_pkg::EVICT_EN_BIT];                   // R7
      end
      if (pstrb_i[icu_pkg::EVICT_THR_LANE]) begin
        evict_thr <= pwdata_i[icu_pkg::EVICT_THR_LSB +: 4];
      end
    end
  end

  // Trigger pulses, gated by the enable already held
  assign merge_man   = wr_ctrl && pstrb_i[icu_pkg::MERGE_LANE] && pwdata_i[icu_pkg::MERGE_TRIG_BIT]; // R1 R13
  assign merge_auto  = merge_reach;                                    // R4
  assign merge_start = (merge_man || merge_auto) && merge_en && msg_intr_present_i
                       && (m_state == icu_pkg::M_IDLE);                // R2 R11
  assign evict_man   = wr_ctrl && pstrb_i[icu_pkg::EVICT_LANE] && pwdata_i[icu_pkg::EVICT_TRIG_BIT]; // R5 R13
  assign evict_auto  = evict_reach;                                    // R8
  assign evict_start = (evict_man || evict_auto) && evict_en && msg_intr_present_i
                       && (e_state == icu_pkg::E_IDLE);                // R6 R11

  // Bank occupancy and threshold watchers
  assign occ0 = bank_count(valid, 1'b0);
  assign occ1 = bank_count(valid, 1'b1);

  fill_level_watch u_merge_watch (
    .ref_clk_i     (ref_clk_i),
    .srst_i        (srst_i),
    .occ0_i        (occ0),
    .occ1_i        (occ1),
    .thr_i         (merge_thr),
    .reach_pulse_o (merge_reach)
  );

  fill_level_watch u_evict_watch (
    .ref_clk_i     (ref_clk_i),
    .srst_i        (srst_i),
    .occ0_i        (occ0),
    .occ1_i        (occ1),
    .thr_i         (evict_thr),
    .reach_pulse_o (evict_reach)
  );

  // ID store, read only by the merge engine
  entry_id_store u_ids (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .wr_en_i   (ins_fire),
    .wr_idx_i  (victim),
    .wr_id_i   (ins_id_i),
    .rd_en_i   ((m_state == icu_pkg::M_RDA) || (m_state == icu_pkg::M_RDB)),
    .rd_idx_i  ((m_state == icu_pkg::M_RDA) ? a_idx : b_idx),
    .rd_id_o   (rd_id)
  );

  // Merge engine walk over entry pairs
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      m_state <= icu_pkg::M_IDLE;
      a_idx   <= '0;
      b_idx   <= '0;
      a_id    <= '0;
    end else begin
      case (m_state)
        icu_pkg::M_IDLE: begin
          if (merge_start) begin
            m_state <= icu_pkg::M_RDA;                                 // R1
            a_idx   <= '0;
          end
        end
        icu_pkg::M_RDA: begin
          m_state <= icu_pkg::M_LDA;
        end
        icu_pkg::M_LDA: begin
          if (a_idx == icu_pkg::LAST_IDX) begin
            m_state <= icu_pkg::M_IDLE;
          end else if (valid[a_idx] && !ser[a_idx]) begin
            a_id    <= rd_id;
            b_idx   <= a_idx + 1'b1;
            m_state <= icu_pkg::M_RDB;
          end else begin
            a_idx   <= a_idx + 1'b1;
            m_state <= icu_pkg::M_RDA;
          end
        end
        icu_pkg::M_RDB: begin
          m_state <= icu_pkg::M_CMP;
        end
        icu_pkg::M_CMP: begin
          if (b_idx != icu_pkg::LAST_IDX) begin
            b_idx   <= b_idx + 1'b1;
            m_state <= icu_pkg::M_RDB;
          end else begin
            a_idx   <= a_idx + 1'b1;
            m_state <= icu_pkg::M_RDA;
          end
        end
        default: begin
          m_state <= icu_pkg::M_IDLE;
        end
      endcase
    end
  end

  // Second unserialized copy of the same ID folds into the first
  assign merge_kill = (m_state == icu_pkg::M_CMP) && valid[a_idx] && valid[b_idx]
                      && !ser[b_idx] && (rd_id == a_id);               // R1

  // Eviction engine, one entry per cycle
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      e_state <= icu_pkg::E_IDLE;
      e_idx   <= '0;
    end else begin
      case (e_state)
        icu_pkg::E_IDLE: begin
          if (evict_start) begin
            e_state <= icu_pkg::E_SCAN;                                // R5
            e_idx   <= '0;
          end
        end
        icu_pkg::E_SCAN: begin
          e_idx <= e_idx + 1'b1;
          if (e_idx == icu_pkg::LAST_IDX) begin
            e_state <= icu_pkg::E_IDLE;
          end
        end
        default: begin
          e_state <= icu_pkg::E_IDLE;
        end
      endcase
    end
  end

  assign evict_kill   = (e_state == icu_pkg::E_SCAN) && valid[e_idx] && !enab[e_idx]; // R5
  assign merge_busy_o = (m_state != icu_pkg::M_IDLE);
  assign evict_busy_o = (e_state != icu_pkg::E_IDLE);

  // Victim choice: free slot, else a disabled entry
  assign free_pick   = pick_first(valid);
  assign dis_pick    = pick_first(enab);
  assign victim      = free_pick[icu_pkg::IDX_W] ? free_pick[icu_pkg::IDX_W-1:0]
                                                 : dis_pick[icu_pkg::IDX_W-1:0]; // R9
  assign ins_ready_o = msg_intr_present_i && !merge_busy_o && !evict_busy_o
                       && (free_pick[icu_pkg::IDX_W] || dis_pick[icu_pkg::IDX_W]); // R9
  assign ins_fire    = ins_valid_i && ins_ready_o;
  assign ins_replace = ins_fire && !free_pick[icu_pkg::IDX_W];

  // Entry valid flags
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      valid <= '0;
    end else begin
      if (merge_kill) begin
        valid[b_idx] <= 1'b0;
      end
      if (evict_kill) begin
        valid[e_idx] <= 1'b0;
      end
      if (ins_fire) begin
        valid[victim] <= 1'b1;
      end
    end
  end

  // Entry enable flags
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      enab <= '0;
    end else begin
      if (en_valid_i) begin
        enab[en_idx_i] <= en_value_i;
      end
      if (ins_fire) begin
        enab[victim] <= ins_enabled_i;
      end
    end
  end

  // Serialization flags, a new arrival wins over the insertion clear
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ser <= '0;
    end else begin
      if (ins_fire) begin
        ser[victim] <= 1'b0;
      end
      if (ser_valid_i) begin
        ser[ser_idx_i] <= 1'b1;
      end
    end
  end

  // Eviction report; nothing here is sent off chip
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      evict_valid_o <= 1'b0;
      evict_idx_o   <= '0;
    end else begin
      evict_valid_o <= evict_kill || ins_replace;                      // R12
      evict_idx_o   <= evict_kill ? e_idx : victim;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  chk_merge_trig_start: assert property ( // R1
    wr_ctrl && pstrb_i[icu_pkg::MERGE_LANE] && pwdata_i[icu_pkg::MERGE_TRIG_BIT] && merge_en
    && msg_intr_present_i && !merge_busy_o
    |=> m_state == icu_pkg::M_RDA ##1 m_state == icu_pkg::M_LDA)
    else $error("merge trigger did not start the engine");

  chk_merge_trig_gate: assert property ( // R2
    !merge_en && !merge_busy_o |=> !merge_busy_o)
    else $error("merge engine ran while disabled");

  chk_merge_en_hold: assert property ( // R3
    !wr_ctrl |=> $stable(merge_en) && $stable(evict_en))
    else $error("engine enable changed without a write");

  chk_merge_auto: assert property ( // R4
    $rose(merge_busy_o) |-> $past(merge_man || merge_reach))
    else $error("merge engine started without a trigger");

  chk_evict_scan_len: assert property ( // R5
    $rose(evict_busy_o) |-> evict_busy_o [*8] ##1 evict_busy_o [*8] ##1 !evict_busy_o)
    else $error("eviction scan length wrong");

  chk_evict_removes: assert property ( // R5
    evict_busy_o && valid[e_idx] && !enab[e_idx]
    |=> evict_valid_o && evict_idx_o == $past(e_idx) && !valid[$past(e_idx)])
    else $error("disabled entry not evicted");

  chk_evict_trig_gate: assert property ( // R6
    !evict_en && !evict_busy_o |=> !evict_busy_o)
    else $error("eviction engine ran while disabled");

  chk_victim_disabled: assert property ( // R9
    ins_fire && !free_pick[icu_pkg::IDX_W] |-> !enab[victim] ##1 evict_valid_o)
    else $error("victim was not a disabled entry");

  chk_ctrl_read_zero: assert property ( // R10
    setup_rd && !pwrite_i && paddr_i == icu_pkg::CTRL_OFFSET
    |=> prdata_o[29:20] == 10'h000 && prdata_o[13:4] == 10'h000 && !prdata_o[31] && !prdata_o[15])
    else $error("reserved or trigger bits read non-zero");

  chk_no_msg_idle: assert property ( // R11
    !msg_intr_present_i && !merge_busy_o && !evict_busy_o |=> !merge_busy_o && !evict_busy_o)
    else $error("engine ran without message interrupt support");

  cov_merge_fold: cover property (merge_kill);
  cov_evict_engine: cover property (evict_kill);
  cov_victim_replace: cover property (ins_replace);
  cov_auto_merge: cover property (merge_reach && merge_en && !merge_busy_o);

endmodule // intr_cache_util_engine

`default_nettype wire

// File: testbench/tb_intr_cache_util_engine.sv
// Self-checking bench for the interrupt cache utilization engine
`timescale 1ns/1ns
`default_nettype none

module tb_intr_cache_util_engine;
  localparam logic [11:0] CTRL = icu_pkg::CTRL_OFFSET;
  localparam logic [11:0] STAT = icu_pkg::STATUS_OFFSET;

  // Design inputs
  logic               ref_clk_i = 1'b0;
  logic               srst_i    = 1'b1;
  logic               psel_i    = 1'b0;
  logic               penable_i = 1'b0;
  logic               pwrite_i  = 1'b0;
  logic [11:0]        paddr_i   = 12'h000;
  logic [31:0]        pwdata_i  = 32'h0000_0000;
  logic               msg_i     = 1'b1;
  logic               ins_v     = 1'b0;
  icu_pkg::entry_id_t ins_id    = 16'h0000;
  logic               ins_en    = 1'b0;
  logic               ser_v     = 1'b0;
  logic               en_v      = 1'b0;
  icu_pkg::idx_t      upd_idx   = 4'h0;
  logic               en_val    = 1'b0;
  // Design outputs
  logic [31:0]        prdata_o;
  logic               pready_o;
  logic               pslverr_o;
  logic               ins_ready_o;
  logic               evict_valid_o;
  icu_pkg::idx_t      evict_idx_o;
  logic               merge_busy_o;
  logic               evict_busy_o;
  // Bench state
  int                 n_errors  = 0;
  int                 cmp_count = 0;
  int                 ev_n      = 0;
  icu_pkg::idx_t      ev_idx;
  logic [31:0]        rd;
  logic               er;

  // Clock
  always #20 ref_clk_i = ~ref_clk_i;

  // Design under test
  intr_cache_util_engine dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .msg_intr_present_i(msg_i), .ins_valid_i(ins_v), .ins_id_i(ins_id),
    .ins_enabled_i(ins_en), .ins_ready_o(ins_ready_o), .ser_valid_i(ser_v),
    .ser_idx_i(upd_idx), .en_valid_i(en_v), .en_idx_i(upd_idx), .en_value_i(en_val),
    .evict_valid_o(evict_valid_o), .evict_idx_o(evict_idx_o),
    .merge_busy_o(merge_busy_o), .evict_busy_o(evict_busy_o)
  );

  // Eviction report monitor
  always @(posedge ref_clk_i) begin
    if (evict_valid_o === 1'b1) begin
      ev_n <= ev_n + 1;
      ev_idx <= evict_idx_o;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Synchronous reset held for three cycles
  task automatic rst();
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
  endtask

  // One APB transfer, result left in rd and er
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("mismatch at %0t: no pready", $time);
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // Insert one entry, held until accepted
  task automatic ins(input icu_pkg::entry_id_t id, input logic en);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    ins_v <= 1'b1;
    ins_id <= id;
    ins_en <= en;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ins_ready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("mismatch at %0t: insert never accepted", $time);
    end
    ins_v <= 1'b0;
  endtask

  // One-cycle serialization or enable update pulse
  task automatic upd(input logic ser, input icu_pkg::idx_t i, input logic v);
    @(posedge ref_clk_i);
    ser_v <= ser;
    en_v <= !ser;
    upd_idx <= i;
    en_val <= v;
    @(posedge ref_clk_i);
    ser_v <= 1'b0;
    en_v <= 1'b0;
  endtask

  // Edges with the chosen engine busy
  task automatic busy_run(input logic m, output int len);
    len = 0;
    do begin
      @(posedge ref_clk_i);
      len++;
    end while ((m ? merge_busy_o : evict_busy_o) === 1'b1 && len < 400);
    len--;
  endtask

  task automatic idle_chk();
    repeat (4) begin
      @(posedge ref_clk_i);
      check({merge_busy_o, evict_busy_o}, 32'h0, "engines idle");
    end
  endtask

  // Watchdog
  initial begin
    #(40 * 5000);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test();
  end

  // Test sequence
  initial begin
    int len;
    int base;
    rst();
    // Reset value, refused triggers, read-back, unmapped address
    apb(1'b0, CTRL, 32'h0);
    check(rd, 32'h000c_000c, "ctrl reset");
    apb(1'b1, CTRL, 32'hffff_ffff);
    idle_chk();
    apb(1'b0, CTRL, 32'h0);
    check(rd, 32'h400f_400f, "ctrl readback");
    apb(1'b0, 12'h008, 32'h0);
    check(er, 1'b1, "unmapped read error");
    check(rd, 32'h0, "unmapped read data");
    $display("test register access done");
    // Merge of unserialized duplicates
    rst();
    apb(1'b1, CTRL, 32'h400c_000c);
    repeat (3) ins(16'h0abc, 1'b1);
    upd(1'b1, 4'h2, 1'b0);
    apb(1'b0, STAT, 32'h0);
    check(rd, 32'h0000_0300, "occupancy before merge");
    base = ev_n;
    apb(1'b1, CTRL, 32'hc00c_000c);
    busy_run(1'b1, len);
    check(len > 0 && len < 400, 1, "merge ran");
    check(ev_n - base, 0, "merge reports no eviction");
    apb(1'b0, STAT, 32'h0);
    check(rd, 32'h0000_0200, "occupancy after merge");
    $display("test merge done");
    // Victim choice and eviction engine on a full cache
    rst();
    for (int i = 0; i < 16; i++) ins(16'h0100 + 16'(i), i != 5);
    upd(1'b0, 4'h9, 1'b0);
    apb(1'b0, STAT, 32'h0);
    check(rd, 32'h0008_0800, "full occupancy");
    ins(16'h0200, 1'b1);
    @(posedge ref_clk_i);
    check({evict_valid_o, evict_idx_o}, {1'b1, 4'h5}, "victim");
    apb(1'b1, CTRL, 32'h000c_400c);
    base = ev_n;
    apb(1'b1, CTRL, 32'h000c_c00c);
    busy_run(1'b0, len);
    check(len, 16, "evict duration");
    check(ev_n - base, 1, "evict count");
    check(ev_idx, 4'h9, "evicted index");
    $display("test eviction done");
    // Automatic start at half full
    rst();
    apb(1'b1, CTRL, 32'h4008_4008);
    for (int i = 1; i < 5; i++) ins(16'(i), 1'b1);
    len = 0;
    do begin
      @(posedge ref_clk_i);
      len++;
    end while ({merge_busy_o, evict_busy_o} !== 2'b11 && len < 6);
    check(len < 6, 1, "auto start");
    repeat (300) @(posedge ref_clk_i);
    $display("test automatic start done");
    // Configuration without message interrupts
    msg_i <= 1'b0;
    rst();
    @(posedge ref_clk_i);
    check(ins_ready_o, 1'b0, "insert refused");
    apb(1'b1, CTRL, 32'h4000_4000);
    apb(1'b1, CTRL, 32'hc000_c000);
    idle_chk();
    $display("test no message interrupts done");
    end_of_test();
  end
endmodule // tb_intr_cache_util_engine

`default_nettype wire
